// >>> hw/dog_defines.svh
// constants for the dual output clock gate
`ifndef DOG_DEFINES_SVH
`define DOG_DEFINES_SVH

// system clock rate in MHz (period 100 ns)
`define DOG_SYS_CLK_MHZ        10
// supply turn-on delay in microseconds after leaving the all-off state
`define DOG_TON_US             200
// width in bits of the source period counter, which counts system cycles
`define DOG_PERIOD_W           8
// width of the turn-on delay counter
`define DOG_TON_W              12
// level that a disabled gated output rests at
`define DOG_REST_LEVEL         1'h0

`endif

// >>> hw/dog_gate_chan.sv
// one gated clock channel: request capture and output gate
`timescale 1ns/1ps
`default_nettype none
`include "dog_defines.svh"

module dog_gate_chan (
    // clock and control
    input  wire logic clk_sys_in,
    input  wire logic rst_in,
    input  wire logic ce_in,
    // request and channel clock
    input  wire logic request_in,
    input  wire logic level_in,
    input  wire logic fall_in,
    // gated clock
    output logic      gated_out,
    output logic      gate_en_out
);
    import dog_pkg::*;

    logic gate_en;

    // request is taken on fall_in: the channel's own falling edge, when the channel clock is low,
    // or any cycle the top's source stage is shut, so the gate shuts mid pulse only at all-off
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            gate_en <= 1'h0;
        end else if (ce_in && fall_in) begin
            gate_en <= request_in;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            gated_out <= `DOG_REST_LEVEL;
        end else if (ce_in) begin
            gated_out <= gate_en ? level_in : `DOG_REST_LEVEL;
        end
    end

    assign gate_en_out = gate_en;

    a_gate_only_fall: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (!(ce_in && fall_in)) |=> $stable(gate_en))
        else $error("gate enable changed away from a falling edge");

    a_rest_when_off: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (ce_in && !gate_en) |=> (gated_out == `DOG_REST_LEVEL))
        else $error("disabled output left its rest level");

    a_gate_opens_low: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        $rose(gate_en) |-> !$past(level_in))
        else $error("gate opened while channel clock was high");

endmodule
`default_nettype wire

// >>> hw/dog_pkg.sv
// types for the dual output clock gate
package dog_pkg;

    // state of the regulated supply for the clock path
    typedef enum logic [1:0] {
        DOG_SUPPLY_OFF,
        DOG_SUPPLY_RAMP,
        DOG_SUPPLY_ON
    } dog_supply_type;

endpackage

// >>> hw/dog_top.sv
// dual output clock gate: source stage, duty regeneration, supply and two gates
`timescale 1ns/1ps
`default_nettype none
`include "dog_defines.svh"

// Contract
// - output a runs while request a is high and stays off while it is low.
// - output b runs while request b is high and stays off while it is low.
// - each output is steered by its own request only, whatever the other does; the code also gates each by supply_valid, which either request holds up.
// - the regulator enable is low when both requests are low and high otherwise.
// - with both requests low the source input stage is shut and ignores the source.
// - output b is the inverse of the source clock and output a follows its polarity.
// - outputs switch on and off in step with the source, but shutting the stage at all-off may cut a running pulse short.
// - each request is held in a storage element that directly gates its output.
// - output a's gate enable is updated on the regenerated clock's falling edge, half a period after the rise.
// - output b's gate enable is updated on the source rising edge, output b's fall.
// - the outputs are regenerated to a 50% duty cycle from a slightly uneven source.
// - after leaving all-off the supply becomes valid after about 200 us.
module dog_top #(
    parameter int PERIOD_W = `DOG_PERIOD_W,
    parameter int TON_W    = `DOG_TON_W
) (
    // clock, reset and enable
    input  wire logic clk_sys_in,
    input  wire logic rst_in,
    input  wire logic ce_in,
    // source clock and requests
    input  wire logic src_clk_in,
    input  wire logic request_a_in,
    input  wire logic request_b_in,
    // gated clocks
    output logic      gated_out_a_out,
    output logic      gated_out_b_out,
    // supply control and status
    output logic      reg_en_out,
    output logic      supply_valid_out,
    output dog_pkg::dog_supply_type supply_state_out
);
    import dog_pkg::*;

    localparam int TON_CYCLES_INT = `DOG_TON_US * `DOG_SYS_CLK_MHZ;
    localparam logic [TON_W-1:0] TON_CYCLES = TON_W'(TON_CYCLES_INT);
    localparam logic [PERIOD_W-1:0] CNT_MAX = {PERIOD_W{1'b1}};

    logic                reg_en;
    logic                stage_on;
    logic                src_q;
    logic                src_d;
    logic                src_rise;
    logic [PERIOD_W-1:0] cnt;
    logic [PERIOD_W-1:0] period;
    logic [PERIOD_W-1:0] half;
    logic                regen;
    logic                regen_d;
    logic                regen_rise;
    logic                regen_fall;
    logic                next_regen;
    dog_supply_type      supply;
    dog_supply_type      next_supply;
    logic [TON_W-1:0]    ton_cnt;
    logic                supply_valid;
    logic                req_a_ok;
    logic                req_b_ok;
    logic                gate_en_a;
    logic                gate_en_b;

    // regulator enable from the two requests
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            reg_en <= 1'h0;
        end else if (ce_in) begin
            reg_en <= request_a_in | request_b_in;
        end
    end

    assign stage_on = reg_en;

    // input stage: holds still while shut, so a running source costs nothing
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            src_q <= 1'h0;
            src_d <= 1'h0;
        end else if (ce_in && stage_on) begin
            src_q <= src_clk_in;
            src_d <= src_q;
        end
    end

    assign src_rise = stage_on & src_q & ~src_d;

    // period measure between source rising edges, saturating
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            cnt    <= '0;
            period <= '0;
        end else if (ce_in) begin
            if (!stage_on) begin
                cnt    <= '0;
                period <= '0;
            end else if (src_rise) begin
                period <= (cnt == CNT_MAX) ? CNT_MAX : cnt + PERIOD_W'(1);
                cnt    <= '0;
            end else if (cnt != CNT_MAX) begin
                cnt <= cnt + PERIOD_W'(1);
            end
        end
    end

    assign half = period >> 1;

    // regenerated clock: high for the first half of the measured period.
    // until a period is known the sampled source passes as it is; odd
    // periods lose the odd cycle to the low phase, the best a whole
    // cycle grid allows
    always_comb begin
        next_regen = src_q;
        if (!stage_on) begin
            next_regen = 1'h0;
        end else if (period >= PERIOD_W'(2)) begin
            if (src_rise) begin
                next_regen = 1'h1;
            end else begin
                next_regen = (cnt + PERIOD_W'(1)) < half;
            end
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            regen   <= 1'h0;
            regen_d <= 1'h0;
        end else if (ce_in) begin
            regen   <= next_regen;
            regen_d <= regen;
        end
    end

    assign regen_rise = regen & ~regen_d;
    assign regen_fall = ~regen & regen_d;

    // supply sequencing: the path is trusted only after the turn-on delay
    always_comb begin
        next_supply = supply;
        case (supply)
            DOG_SUPPLY_OFF: begin
                if (reg_en) begin
                    next_supply = DOG_SUPPLY_RAMP;
                end
            end
            DOG_SUPPLY_RAMP: begin
                if (!reg_en) begin
                    next_supply = DOG_SUPPLY_OFF;
                end else if (ton_cnt >= TON_CYCLES - TON_W'(1)) begin
                    next_supply = DOG_SUPPLY_ON;
                end
            end
            DOG_SUPPLY_ON: begin
                if (!reg_en) begin
                    next_supply = DOG_SUPPLY_OFF;
                end
            end
            default: begin
                next_supply = DOG_SUPPLY_OFF;
            end
        endcase
    end

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            supply <= DOG_SUPPLY_OFF;
        end else if (ce_in) begin
            supply <= next_supply;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            ton_cnt <= '0;
        end else if (ce_in) begin
            if (supply == DOG_SUPPLY_RAMP) begin
                ton_cnt <= ton_cnt + TON_W'(1);
            end else begin
                ton_cnt <= '0;
            end
        end
    end

    assign supply_valid = (supply == DOG_SUPPLY_ON);

    // each channel sees its own request, gated by supply_valid
    assign req_a_ok = request_a_in & supply_valid;
    assign req_b_ok = request_b_in & supply_valid;

    // channel a follows the source, gate taken on its falling edge
    dog_gate_chan u_chan_a (
        .clk_sys_in  (clk_sys_in),
        .rst_in      (rst_in),
        .ce_in       (ce_in),
        .request_in  (req_a_ok),
        .level_in    (regen),
        // a shut stage makes no more edges, so the gate is reloaded
        // while shut; otherwise a stale gate would reopen before supply valid
        .fall_in     (regen_fall | ~stage_on),
        .gated_out   (gated_out_a_out),
        .gate_en_out (gate_en_a)
    );

    // channel b is inverted, so the source rise is its own fall
    dog_gate_chan u_chan_b (
        .clk_sys_in  (clk_sys_in),
        .rst_in      (rst_in),
        .ce_in       (ce_in),
        .request_in  (req_b_ok),
        .level_in    (~regen),
        // with the stage shut the inverted level sits high, so a gate left
        // open would hold output b high for good; shutting may cut its last pulse
        .fall_in     (regen_rise | ~stage_on),
        .gated_out   (gated_out_b_out),
        .gate_en_out (gate_en_b)
    );

    assign reg_en_out       = reg_en;
    assign supply_valid_out = supply_valid;
    assign supply_state_out = supply;

    a_reg_en_both_low: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (ce_in && !request_a_in && !request_b_in) |=> !reg_en_out)
        else $error("regulator enabled with both requests low");

    a_reg_en_one_high: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (ce_in && (request_a_in || request_b_in)) |=> reg_en_out)
        else $error("regulator off with a request high");

    a_stage_shut_hold: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        !stage_on |=> ($stable(src_q) && !regen))
        else $error("input stage moved while shut");

    a_out_b_inverse: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        ($past(ce_in) && gated_out_b_out) |-> !$past(regen))
        else $error("output b not inverse of source");

    a_out_a_follow: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        ($past(ce_in) && gated_out_a_out) |-> $past(regen))
        else $error("output a not following source");

    a_supply_wait_on: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        $rose(reg_en) |-> !supply_valid [*8])
        else $error("supply valid too early after turn on");

    a_supply_count_on: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        $rose(supply_valid) |-> ($past(ton_cnt) == TON_CYCLES - TON_W'(1)))
        else $error("supply valid at wrong delay");

    a_a_off_no_req: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (ce_in && !request_a_in && regen_fall) |=> ##1 !gated_out_a_out [*2])
        else $error("output a ran without request");

    a_b_off_no_req: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (ce_in && !request_b_in && regen_rise) |=> ##1 !gated_out_b_out [*2])
        else $error("output b ran without request");

    a_duty_high_half: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (ce_in && stage_on && period >= PERIOD_W'(2) && !src_rise && regen_d && regen)
        |-> (cnt < half))
        else $error("regenerated high phase past half period");

endmodule
`default_nettype wire

// >>> verif/dog_periph_model.sv
// partner model: free-running oscillator and two requesting peripherals
`timescale 1ns/1ps
`default_nettype none

module dog_periph_model #(
    parameter int SRC_HI = 2,
    parameter int SRC_LO = 6,
    parameter bit TIE_A  = 1'b0
) (
    // clock
    input  wire logic clk_sys_in,
    // wishes of the two peripherals
    input  wire logic want_a_in,
    input  wire logic want_b_in,
    // towards the gate
    output var logic  src_clk_out,
    output logic      request_a_out,
    output logic      request_b_out
);
    int phase;

    initial begin
        phase = 0;
        src_clk_out = 1'b0;
    end

    // uneven duty on purpose so the duty regeneration has work to do;
    // the source rate is scaled down to what the system clock can sample
    always @(posedge clk_sys_in) begin
        #1;
        phase = (phase + 1) % (SRC_HI + SRC_LO);
        src_clk_out = (phase < SRC_HI);
    end

    // a peripheral without request ability is strapped high
    assign request_a_out = TIE_A | want_a_in;
    assign request_b_out = want_b_in;
endmodule

`default_nettype wire

// >>> verif/test_dual_output_clock_gate.sv
// self-checking bench for the dual output clock gate
`timescale 1ns/1ps
`default_nettype none

`define CHECK(got, exp) begin n_compared++; if ((got) !== (exp)) begin errors++; \
    $display("Error at %0t: got %h expected %h", $time, (got), (exp)); end end

module test_dual_output_clock_gate;
    import dog_pkg::*;

    logic           clk_sys_in = 1'b0;
    logic           rst_in = 1'b1;
    logic           want_a = 1'b0;
    logic           want_b = 1'b0;
    logic           src_clk, request_a, request_b;
    logic           gated_out_a_out, gated_out_b_out, reg_en_out, supply_valid_out;
    dog_supply_type supply_state_out;
    int             errors = 0;
    int             n_compared = 0;
    int             cycles = 0;

    dog_periph_model dog_periph_model_inst (
        .clk_sys_in    (clk_sys_in),
        .want_a_in     (want_a),
        .want_b_in     (want_b),
        .src_clk_out   (src_clk),
        .request_a_out (request_a),
        .request_b_out (request_b)
    );

    dog_top dog_top_inst (
        .clk_sys_in       (clk_sys_in),
        .rst_in           (rst_in),
        .ce_in            (1'b1),
        .src_clk_in       (src_clk),
        .request_a_in     (request_a),
        .request_b_in     (request_b),
        .gated_out_a_out  (gated_out_a_out),
        .gated_out_b_out  (gated_out_b_out),
        .reg_en_out       (reg_en_out),
        .supply_valid_out (supply_valid_out),
        .supply_state_out (supply_state_out)
    );

    initial begin
        forever #50 clk_sys_in = ~clk_sys_in;
    end

    task automatic stop_test();
        if (errors == 0 && n_compared > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    // the whole run needs about 2700 cycles
    always @(posedge clk_sys_in) begin
        cycles++;
        if (cycles == 6000) begin
            errors++;
            stop_test();
        end
    end

    task automatic drive(input logic a, input logic b);
        @(posedge clk_sys_in);
        #1;
        want_a = a;
        want_b = b;
    endtask

    // counts whole high pulses; a pulse already running at the start is skipped
    task automatic watch(input int n, output int pa, output int pb);
        int  ra, rb;
        bit  sa, sb;
        pa = 0; pb = 0; ra = 0; rb = 0;
        sa = gated_out_a_out; sb = gated_out_b_out;
        repeat (n) begin
            @(posedge clk_sys_in);
            #2;
            if (gated_out_a_out === 1'b1) ra++;
            else begin
                if (ra > 0 && !sa) begin `CHECK(ra, 4) pa++; end
                ra = 0; sa = 0;
            end
            if (gated_out_b_out === 1'b1) rb++;
            else begin
                if (rb > 0 && !sb) begin `CHECK(rb, 4) pb++; end
                rb = 0; sb = 0;
            end
        end
    endtask

    task automatic test_supply();
        int n;
        drive(1'b1, 1'b0);
        `CHECK(reg_en_out, 1'b0)
        @(posedge clk_sys_in);
        #2;
        `CHECK(reg_en_out, 1'b1)
        n = 1;
        while (supply_valid_out !== 1'b1 && n < 2100) begin
            @(posedge clk_sys_in);
            #2;
            n++;
        end
        `CHECK(n >= 2000 && n <= 2004, 1'b1)
        `CHECK(supply_state_out, DOG_SUPPLY_ON)
    endtask

    task automatic test_a_only();
        int pa, pb;
        watch(200, pa, pb);
        `CHECK(pa > 10, 1'b1)
        `CHECK(pb, 0)
    endtask

    task automatic test_both();
        int pa, pb;
        drive(1'b1, 1'b1);
        watch(40, pa, pb);
        repeat (100) begin
            @(posedge clk_sys_in);
            #2;
            `CHECK(gated_out_b_out, ~gated_out_a_out)
        end
        watch(100, pa, pb);
        `CHECK(pb > 5, 1'b1)
    endtask

    task automatic test_drop_a();
        int pa, pb;
        drive(1'b0, 1'b1);
        watch(40, pa, pb);
        watch(60, pa, pb);
        `CHECK(pa, 0)
        `CHECK(pb > 3, 1'b1)
        `CHECK(reg_en_out, 1'b1)
    endtask

    task automatic test_all_off();
        drive(1'b0, 1'b0);
        @(posedge clk_sys_in);
        #2;
        `CHECK(reg_en_out, 1'b0)
        repeat (20) @(posedge clk_sys_in);
        #2;
        `CHECK(supply_state_out, DOG_SUPPLY_OFF)
        repeat (60) begin
            @(posedge clk_sys_in);
            #2;
            `CHECK({gated_out_a_out, gated_out_b_out, supply_valid_out}, 3'h0)
        end
    endtask

    initial begin
        repeat (8) @(posedge clk_sys_in);
        #1;
        rst_in = 1'b0;
        test_supply();
        test_a_only();
        test_both();
        test_drop_a();
        test_all_off();
        stop_test();
    end
endmodule

`default_nettype wire
